// [ims_pkg.sv]
// ims_pkg: register offsets, field positions, reset values and sequencer states
// for the i2c master condition sequencer; shared by every design file.
package ims_pkg;

	// register offsets on the plain register port
	localparam logic [2:0] ADDR_CTRL1 = 3'h0; // port control and sticky flags
	localparam logic [2:0] ADDR_CTRL2 = 3'h1; // second_control_reg: sequence enables
	localparam logic [2:0] ADDR_STAT = 3'h2; // serial_status_reg
	localparam logic [2:0] ADDR_BAUD = 3'h3; // baud_reload_value
	localparam logic [2:0] ADDR_BUF = 3'h4; // shift_buffer

	// control register 1 fields
	localparam int C1_WRITE_COLLISION_FLAG = 7; // write_collision_flag
	localparam int C1_BCOL = 6; // bus_collision_flag
	localparam int C1_EN = 5; // serial port module enable
	localparam int C1_EVT = 4; // serial_event_flag
	localparam int C1_IE = 0; // serial event interrupt enable

	// second control register fields
	localparam int C2_ACK_DATA_VALUE = 5; // ack_data_value
	localparam int C2_ACK_SEQUENCE_ENABLE = 4; // ack_sequence_enable
	localparam int C2_STOPEN = 2; // stop_sequence_enable
	localparam int C2_STARTEN = 0; // start sequence enable

	// status register fields
	localparam int ST_STOP = 4; // stop detected
	localparam int ST_START = 3; // start detected
	localparam int ST_BF = 0; // buffer_full_flag

	// widths, reset values and counts
	localparam int DW = 8; // data and register width
	localparam logic [7:0] BAUD_RESET = 8'h13; // reload after reset
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [3:0] LAST_BIT = 4'h8; // ninth clock carries the acknowledge
	localparam logic [3:0] BF_BIT = 4'h7; // eighth shift empties the buffer

	// sequencer states, gray coded in declaration order
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_START_A = 4'h1,
		S_START_B = 4'h3,
		S_TX_LOW = 4'h2,
		S_TX_WAIT = 4'h6,
		S_TX_HIGH = 4'h7,
		S_ACK_LOW = 4'h5,
		S_ACK_WAIT = 4'h4,
		S_ACK_HIGH = 4'hC,
		S_STOP_A = 4'hD,
		S_STOP_B = 4'hF,
		S_STOP_C = 4'hE,
		S_STOP_D = 4'hA,
		S_STOP_E = 4'hB
	} ims_state_e;

endpackage : ims_pkg

// [ims_sync2.sv]
// ims_sync2: two flip-flop synchroniser for one pin level.
// assumes the input is asynchronous to i_sys_clk; output is a clean level.
`timescale 1ns/100ps
`default_nettype none
module ims_sync2 import ims_pkg::*; #(
	parameter logic RESET_VAL = 1'b1
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// level in and out
	input wire logic i_async,
	output logic o_sync
);
	logic meta; // first stage, read only by the second

	// two stages; idle bus level is high, so reset to that
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			meta <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule : ims_sync2
`default_nettype wire

// [ims_baud_counter.sv]
// ims_baud_counter: reload down counter giving one tick per rollover period.
// assumes i_load is a one-cycle pulse from the sequencer on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ims_baud_counter import ims_pkg::*; (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// control
	input wire logic i_load,
	input wire logic i_stop,
	input wire logic [DW-1:0] i_reload,
	// rollover
	output logic o_tick
);
	logic [DW-1:0] count; // remaining cycles
	logic armed; // one tick per load, then the counter idles

	// tick when armed count reaches zero; kept free of i_load, since the
	// sequencer reloads on the tick and would otherwise close a loop
	assign o_tick = armed & (count == ZERO8);

	// a load wins over stop, so a sequence leaving idle still gets its count
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			count <= ZERO8;
			armed <= 1'b0;
		end else if (i_load) begin
			count <= i_reload;
			armed <= 1'b1;
		end else if (i_stop) begin
			count <= ZERO8; // sequencer rests
			armed <= 1'b0;
		end else if (o_tick) begin
			armed <= 1'b0;
		end else if (armed) begin
			count <= count - 8'h01;
		end
	end
endmodule : ims_baud_counter
`default_nettype wire

// [ims_cond_seq.sv]
// ims_cond_seq: i2c master condition sequencer with start, stop, acknowledge,
// byte send, arbitration and bus start/stop monitoring.
// assumes open-drain pins resolved outside; register port on i_sys_clk.
// How it works
// - ack enable pulls SCL low, drives ack data
// - ack: one period, release SCL, one more
// - ack end clears enable, stops counter, idles
// - buffer write during ack sets write collision
// - SCL held low after ninth clock falls
// - stop: SDA low, count, release SCL, SDA
// - stop seen sets flag; later event, clear
// - buffer write during stop sets write collision
// - in sleep, completed events wake the processor
// - reset disables port, abandons any transfer
// - start/stop bits cleared on reset, disable
// - busy bus: stop detection raises event
// - expected one sampled zero: collision, idle
// - transmit collision: halt, clear full, release
// - sequence collision: abort, release, clear enables
// - after collision, bus stop sets event
// - after collision, writes restart from bit one
// - lines low at start: abort, collide, idle
// - SCL low during first start count: collision
// - SDA early low shortcuts; then count, SCL low
// - counter reloads from baud register, starts on write
`timescale 1ns/100ps
`default_nettype none
module ims_cond_seq import ims_pkg::*; (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// register port
	input wire logic [2:0] i_addr,
	input wire logic [DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DW-1:0] o_rdata,
	// open-drain bus pins
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic i_scl,
	output logic o_scl,
	output logic o_scl_oe,
	// processor side
	input wire logic i_sleep,
	output logic o_event_irq,
	output logic o_wake
);
	// synchronised pins and previous samples
	logic sda_s, scl_s; // synchronised levels
	logic sda_q; // previous synchronised sda, for edges
	ims_state_e state, next_state; // sequencer state
	// software visible state
	logic port_en, event_ie; // control bits
	logic write_collision_flag, bcol, event_flag; // sticky flags
	logic ack_dt, ack_en, stop_en, start_en; // second control bits
	logic start_seen, stop_seen; // bus monitor status
	logic buf_full; // shift buffer holds unsent byte
	logic [DW-1:0] baud_reload; // counter reload
	logic [DW-1:0] shift_buffer; // last byte accepted from a buffer write
	logic [DW-1:0] shifter; // byte on its way out
	logic [3:0] bit_cnt; // clocks sent in this byte
	logic sda_low, scl_low; // lines being pulled low
	logic next_sda_low, next_scl_low;
	// sequencer requests, combinational
	logic brg_load, brg_tick; // counter reload and rollover
	logic seq_event; // own sequence finished
	logic seq_coll; // arbitration lost
	logic clr_start, clr_stop, clr_ack; // enable auto-clears
	logic tx_go, tx_shift, tx_end; // byte send steps
	logic [DW-1:0] next_rdata;

	// register decode
	wire wr_c1 = i_wr & (i_addr == ADDR_CTRL1);
	wire wr_c2 = i_wr & (i_addr == ADDR_CTRL2);
	wire wr_baud = i_wr & (i_addr == ADDR_BAUD);
	wire wr_buf = i_wr & (i_addr == ADDR_BUF);
	// writes land only when idle and enabled; otherwise they collide
	wire buf_ok = wr_buf & port_en & (state == S_IDLE) & ~start_en & ~stop_en & ~ack_en;
	wire buf_coll = wr_buf & ~buf_ok;
	// bus conditions seen while SCL stays high
	wire bus_start = scl_s & sda_q & ~sda_s;
	wire bus_stop = scl_s & ~sda_q & sda_s;
	// external stop seen while sequencer rests raises an event
	wire ext_stop_evt = bus_stop & (state == S_IDLE);

	// pin synchronisers, one per line
	ims_sync2 #(.RESET_VAL(1'b1)) u_sync_sda (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_sda),
		.o_sync(sda_s)
	);
	ims_sync2 #(.RESET_VAL(1'b1)) u_sync_scl (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_scl),
		.o_sync(scl_s)
	);

	// rollover counter; stopped whenever the sequencer rests
	ims_baud_counter u_baud (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_load(brg_load),
		.i_stop(state == S_IDLE),
		.i_reload(baud_reload),
		.o_tick(brg_tick)
	);

	// sequencer next state; first enable set wins from idle
	always_comb begin
		next_state = state;
		next_sda_low = sda_low;
		next_scl_low = scl_low;
		brg_load = 1'b0;
		seq_event = 1'b0;
		seq_coll = 1'b0;
		clr_start = 1'b0;
		clr_stop = 1'b0;
		clr_ack = 1'b0;
		tx_go = 1'b0;
		tx_shift = 1'b0;
		tx_end = 1'b0;
		case (state)
			S_IDLE: begin
				// lines keep their last level, so SCL stays low after a byte
				if (start_en) begin
					if (!sda_s || !scl_s) begin
						seq_coll = 1'b1;
					end else begin
						brg_load = 1'b1;
						next_state = S_START_A;
					end
				end else if (stop_en) begin
					next_sda_low = 1'b1;
					next_scl_low = 1'b1;
					next_state = S_STOP_A;
				end else if (ack_en) begin
					next_scl_low = 1'b1;
					next_sda_low = ~ack_dt;
					brg_load = 1'b1;
					next_state = S_ACK_LOW;
				end else if (buf_ok) begin
					tx_go = 1'b1;
					brg_load = 1'b1;
					next_scl_low = 1'b1;
					next_sda_low = ~i_wdata[DW-1];
					next_state = S_TX_LOW;
				end
			end
			S_START_A: begin
				if (!sda_s) begin
					// another master took SDA first: assert ours at once
					next_sda_low = 1'b1;
					brg_load = 1'b1;
					next_state = S_START_B;
				end else if (!scl_s) begin
					seq_coll = 1'b1;
				end else if (brg_tick) begin
					next_sda_low = 1'b1;
					brg_load = 1'b1;
					next_state = S_START_B;
				end
			end
			S_START_B: begin
				// SCL low here is ignored by design
				if (brg_tick) begin
					next_scl_low = 1'b1;
					clr_start = 1'b1;
					seq_event = 1'b1;
					next_state = S_IDLE;
				end
			end
			S_TX_LOW: begin
				next_sda_low = ~shifter[DW-1];
				if (brg_tick) begin
					next_scl_low = 1'b0;
					next_state = S_TX_WAIT;
				end
			end
			S_TX_WAIT: begin
				// clock stretching: count only once SCL is really high
				if (scl_s) begin
					brg_load = 1'b1;
					next_state = S_TX_HIGH;
				end
			end
			S_TX_HIGH: begin
				if (shifter[DW-1] && bit_cnt != LAST_BIT && !sda_s) begin
					seq_coll = 1'b1;
				end else if (brg_tick) begin
					next_scl_low = 1'b1;
					tx_shift = 1'b1;
					brg_load = 1'b1;
					next_sda_low = ~shifter[DW-2];
					if (bit_cnt == LAST_BIT) begin
						// hold SCL low after the ninth clock, SDA floating
						next_sda_low = 1'b0;
						tx_end = 1'b1;
						seq_event = 1'b1;
						next_state = S_IDLE;
					end else begin
						next_state = S_TX_LOW;
					end
				end
			end
			S_ACK_LOW: begin
				if (brg_tick) begin
					next_scl_low = 1'b0;
					next_state = S_ACK_WAIT;
				end
			end
			S_ACK_WAIT: begin
				if (scl_s) begin
					brg_load = 1'b1;
					next_state = S_ACK_HIGH;
				end
			end
			S_ACK_HIGH: begin
				if (ack_dt && !sda_s) begin
					seq_coll = 1'b1;
				end else if (brg_tick) begin
					next_scl_low = 1'b1;
					next_sda_low = 1'b0;
					clr_ack = 1'b1;
					seq_event = 1'b1;
					next_state = S_IDLE;
				end
			end
			S_STOP_A: begin
				if (!sda_s) begin
					brg_load = 1'b1;
					next_state = S_STOP_B;
				end
			end
			S_STOP_B: begin
				if (brg_tick) begin
					next_scl_low = 1'b0;
					brg_load = 1'b1;
					next_state = S_STOP_C;
				end
			end
			S_STOP_C: begin
				if (brg_tick) begin
					next_sda_low = 1'b0;
					next_state = S_STOP_D;
				end
			end
			S_STOP_D: begin
				// stop bit itself is set by the bus monitor on this edge
				if (sda_s && scl_s) begin
					brg_load = 1'b1;
					next_state = S_STOP_E;
				end
			end
			S_STOP_E: begin
				if (brg_tick) begin
					clr_stop = 1'b1;
					seq_event = 1'b1;
					next_state = S_IDLE;
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
		// collision or disable: drop everything and release both lines
		if (seq_coll || !port_en) begin
			next_state = S_IDLE;
			next_sda_low = 1'b0;
			next_scl_low = 1'b0;
			clr_start = 1'b1;
			clr_stop = 1'b1;
			clr_ack = 1'b1;
		end
	end

	// sequencer state and line drivers
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state <= S_IDLE;
			sda_low <= 1'b0;
			scl_low <= 1'b0;
			sda_q <= 1'b1;
		end else begin
			state <= next_state;
			sda_low <= next_sda_low;
			scl_low <= next_scl_low;
			sda_q <= sda_s;
		end
	end

	// byte shifter; a collision leaves the count at zero for the next write
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || seq_coll) begin
			bit_cnt <= 4'h0;
			shifter <= ZERO8;
		end else if (tx_go) begin
			bit_cnt <= 4'h0;
			shifter <= i_wdata;
		end else if (tx_end) begin
			bit_cnt <= 4'h0; // byte done, next write starts clean
			shifter <= ZERO8;
		end else if (tx_shift) begin
			bit_cnt <= bit_cnt + 4'h1;
			shifter <= {shifter[DW-2:0], 1'b1};
		end
	end

	// software control bits and buffer contents
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			port_en <= 1'b0;
			event_ie <= 1'b0;
			baud_reload <= BAUD_RESET;
			shift_buffer <= ZERO8;
		end else begin
			if (wr_c1) begin
				port_en <= i_wdata[C1_EN];
				event_ie <= i_wdata[C1_IE];
			end
			if (wr_baud) begin
				baud_reload <= i_wdata;
			end
			if (buf_ok) begin
				shift_buffer <= i_wdata;
			end
		end
	end

	// sequence enables: software sets, hardware clears at end or collision
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ack_dt <= 1'b0;
			ack_en <= 1'b0;
			stop_en <= 1'b0;
			start_en <= 1'b0;
		end else begin
			ack_dt <= wr_c2 ? i_wdata[C2_ACK_DATA_VALUE] : ack_dt;
			ack_en <= ~clr_ack & (wr_c2 ? i_wdata[C2_ACK_SEQUENCE_ENABLE] : ack_en);
			stop_en <= ~clr_stop & (wr_c2 ? i_wdata[C2_STOPEN] : stop_en);
			start_en <= ~clr_start & (wr_c2 ? i_wdata[C2_STARTEN] : start_en);
		end
	end

	// sticky flags: writing zero clears, a hardware set in the same cycle wins
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			write_collision_flag <= 1'b0;
			bcol <= 1'b0;
			event_flag <= 1'b0;
		end else begin
			write_collision_flag <= buf_coll | (write_collision_flag & ~(wr_c1 & ~i_wdata[C1_WRITE_COLLISION_FLAG]));
			bcol <= seq_coll | (bcol & ~(wr_c1 & ~i_wdata[C1_BCOL]));
			event_flag <= seq_event | ext_stop_evt | (event_flag & ~(wr_c1 & ~i_wdata[C1_EVT]));
		end
	end

	// buffer full: set on accepted write, cleared after eighth bit or collision
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || seq_coll) begin
			buf_full <= 1'b0;
		end else if (tx_go) begin
			buf_full <= 1'b1;
		end else if (tx_shift && bit_cnt == BF_BIT) begin
			buf_full <= 1'b0;
		end
	end

	// bus monitor runs even after a collision; cleared while disabled
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !port_en) begin
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
		end else if (bus_start) begin
			start_seen <= 1'b1;
			stop_seen <= 1'b0;
		end else if (bus_stop) begin
			start_seen <= 1'b0;
			stop_seen <= 1'b1;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = ZERO8;
		case (i_addr)
			ADDR_CTRL1: begin
				next_rdata[C1_WRITE_COLLISION_FLAG] = write_collision_flag;
				next_rdata[C1_BCOL] = bcol;
				next_rdata[C1_EN] = port_en;
				next_rdata[C1_EVT] = event_flag;
				next_rdata[C1_IE] = event_ie;
			end
			ADDR_CTRL2: begin
				next_rdata[C2_ACK_DATA_VALUE] = ack_dt;
				next_rdata[C2_ACK_SEQUENCE_ENABLE] = ack_en;
				next_rdata[C2_STOPEN] = stop_en;
				next_rdata[C2_STARTEN] = start_en;
			end
			ADDR_STAT: begin
				next_rdata[ST_STOP] = stop_seen;
				next_rdata[ST_START] = start_seen;
				next_rdata[ST_BF] = buf_full;
			end
			ADDR_BAUD: begin
				next_rdata = baud_reload;
			end
			ADDR_BUF: begin
				next_rdata = shift_buffer;
			end
			default: begin
				next_rdata = ZERO8;
			end
		endcase
	end

	// registered outputs; the pins only ever pull low
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_rdata <= ZERO8;
			o_sda <= 1'b0;
			o_scl <= 1'b0;
			o_sda_oe <= 1'b0;
			o_scl_oe <= 1'b0;
			o_event_irq <= 1'b0;
			o_wake <= 1'b0;
		end else begin
			o_rdata <= i_rd ? next_rdata : ZERO8;
			o_sda <= 1'b0;
			o_scl <= 1'b0;
			o_sda_oe <= next_sda_low;
			o_scl_oe <= next_scl_low;
			o_event_irq <= event_flag & event_ie;
			o_wake <= i_sleep & event_flag & event_ie;
		end
	end
endmodule : ims_cond_seq
`default_nettype wire

// [ims_bus_model.sv]
// ims_bus_model: open-drain bus with pull-ups and one other master.
// assumes every party only ever pulls low; released wires float high.
`timescale 1ns/100ps
`default_nettype none
module ims_bus_model (
	// pull-down enables of every party
	input wire logic i_dut_sda_oe,
	input wire logic i_dut_scl_oe,
	input wire logic i_other_sda_low,
	input wire logic i_other_scl_low,
	// resolved wire levels
	output logic o_sda,
	output logic o_scl
);
	// wired-and: a pull-up wins only while nobody pulls low
	assign o_sda = !(i_dut_sda_oe || i_other_sda_low);
	assign o_scl = !(i_dut_scl_oe || i_other_scl_low);
endmodule : ims_bus_model
`default_nettype wire

// [ims_cond_seq_sva.sv]
// ims_cond_seq_sva: port-level checks for the condition sequencer.
// assumes a bind onto ims_cond_seq and a reload of at least three.
`timescale 1ns/100ps
`default_nettype none
module ims_cond_seq_sva import ims_pkg::*; (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// register port
	input wire logic [2:0] i_addr,
	input wire logic [DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [DW-1:0] o_rdata,
	// pins
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe,
	input wire logic i_scl,
	input wire logic o_scl,
	input wire logic o_scl_oe,
	// processor side
	input wire logic i_sleep,
	input wire logic o_event_irq,
	input wire logic o_wake
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// open drain: only the enables may ever move
	chk_pins_low: assert property (!o_sda && !o_scl) else $error("pin value not low");
	// wake needs an enabled event and sleep one cycle before
	chk_wake_gate: assert property (o_wake |-> o_event_irq && $past(i_sleep)) else $error("wake without cause");
	chk_sleep_wakes: assert property (o_event_irq && $past(i_sleep) |-> o_wake) else $error("no wake in sleep");
	// first edge after reset: both lines released, no event
	chk_quiet_reset: assert property ($rose(i_rst_n) |-> !o_sda_oe && !o_scl_oe && !o_event_irq)
		else $error("busy after reset");
	// every scl high phase lasts a whole rollover period
	chk_scl_high_len: assert property ($fell(o_scl_oe) |-> !o_scl_oe [*3]) else $error("scl high too short");
	// every scl low phase, and the held low, lasts a period
	chk_scl_low_len: assert property ($rose(o_scl_oe) |-> o_scl_oe [*3]) else $error("scl low too short");
	// sda stays low while scl is high (stop setup, data bit)
	chk_stop_hold: assert property ($fell(o_scl_oe) && o_sda_oe |-> o_sda_oe [*3]) else $error("sda moved early");
	// start: sda falls, scl follows a full count later
	chk_start_gap: assert property ($rose(o_sda_oe) && !o_scl_oe |-> !o_scl_oe [*3]) else $error("start too short");
	// main scenarios
	cov_start: cover property ($rose(o_sda_oe) && !o_scl_oe);
	cov_stop: cover property ($fell(o_sda_oe) && !o_scl_oe);
	cov_wake: cover property (o_wake);
endmodule : ims_cond_seq_sva
`default_nettype wire

// [tb.sv]
// tb: self-checking bench for ims_cond_seq with an open-drain bus model.
// assumes a 250 MHz clock; reset rows first, then hand-written cases.
`timescale 1ns/100ps
`default_nettype none
module tb import ims_pkg::*;;
	typedef struct {logic [2:0] a; logic [DW-1:0] v;} ims_row_s; // offset and expected read
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [2:0] i_addr = 3'h0;
	logic [DW-1:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_sleep = 1'b0;
	logic other_sda_low = 1'b0; // other master pulls sda
	logic other_scl_low = 1'b0; // other master pulls scl
	logic [DW-1:0] o_rdata;
	logic o_sda, o_sda_oe, o_scl, o_scl_oe, o_event_irq, o_wake, bus_sda, bus_scl;
	logic [8:0] bits = 9'h000; // wire bits seen at scl rise
	int nclk = 0; // scl rises seen
	int miscompares = 0;
	int checked = 0;
	logic [DW-1:0] d; // last read data
	// reset values; unmapped offsets read zero
	ims_row_s rows [7] = '{'{ADDR_CTRL1, 8'h00}, '{ADDR_CTRL2, 8'h00}, '{ADDR_STAT, 8'h00},
		'{ADDR_BAUD, 8'h13}, '{3'h5, 8'h00}, '{3'h6, 8'h00}, '{3'h7, 8'h00}};

	always #2 i_sys_clk = ~i_sys_clk;
	// capture what the bus carries at each scl rise
	always @(posedge bus_scl) begin
		bits <= {bits[7:0], bus_sda};
		nclk <= nclk + 1;
	end

	ims_cond_seq i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sda(bus_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
		.i_scl(bus_scl), .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_sleep(i_sleep), .o_event_irq(o_event_irq),
		.o_wake(o_wake));
	ims_bus_model i_bus (.i_dut_sda_oe(o_sda_oe), .i_dut_scl_oe(o_scl_oe), .i_other_sda_low(other_sda_low),
		.i_other_scl_low(other_scl_low), .o_sda(bus_sda), .o_scl(bus_scl));

	task automatic cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// one-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [DW-1:0] v);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd
	// bounded poll of one register bit
	task automatic wait_bit(input logic [2:0] a, input int n, input logic v);
		for (int i = 0; i < 400; i++) begin
			rd(a);
			if (d[n] === v) return;
		end
		miscompares++;
		end_of_test();
	endtask : wait_bit
	task automatic start_send(input logic [DW-1:0] b);
		wr(ADDR_CTRL2, 8'h01);
		wait_bit(ADDR_CTRL2, C2_STARTEN, 1'b0);
		wr(ADDR_CTRL1, 8'h21);
		bits = 9'h000;
		nclk = 0;
		wr(ADDR_BUF, b);
	endtask : start_send
	task automatic reset_rows();
		foreach (rows[k]) begin
			rd(rows[k].a);
			cmp(d, rows[k].v);
		end
		cmp({6'h00, o_sda_oe, o_scl_oe}, 8'h00);
	endtask : reset_rows
	task automatic end_of_test();
		$display("counts: %0d checked, %0d miscompares", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (5) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		reset_rows();
		$display("test reset done");
		// byte goes out msb first over nine clocks, scl then held low
		wr(ADDR_CTRL1, 8'h21);
		wr(ADDR_BAUD, 8'h03);
		rd(ADDR_BAUD);
		cmp(d, 8'h03);
		start_send(8'hA5);
		wait_bit(ADDR_CTRL1, C1_EVT, 1'b1);
		cmp(bits[8:1], 8'hA5);
		cmp(nclk[7:0], 8'h09);
		repeat (20) @(posedge i_sys_clk);
		cmp({7'h00, o_scl_oe}, 8'h01);
		$display("test byte done");
		// acknowledge with data 0; buffer write meanwhile refused
		wr(ADDR_BAUD, 8'h05);
		wr(ADDR_CTRL1, 8'h21);
		wr(ADDR_CTRL2, 8'h10);
		wr(ADDR_BUF, 8'h3C);
		rd(ADDR_CTRL1);
		cmp({6'h00, o_sda_oe, o_scl_oe}, 8'h03);
		cmp(d & 8'h80, 8'h80);
		rd(ADDR_BUF);
		cmp(d, 8'hA5);
		wait_bit(ADDR_CTRL2, C2_ACK_SEQUENCE_ENABLE, 1'b0);
		rd(ADDR_CTRL1);
		cmp(d & 8'h10, 8'h10);
		cmp({7'h00, o_scl_oe}, 8'h01);
		$display("test ack done");
		// stop in sleep: refused write, stop seen, event, wake
		wr(ADDR_CTRL1, 8'h21);
		i_sleep <= 1'b1;
		wr(ADDR_CTRL2, 8'h04);
		wr(ADDR_BUF, 8'h11);
		rd(ADDR_CTRL1);
		cmp(d & 8'h80, 8'h80);
		wait_bit(ADDR_CTRL2, C2_STOPEN, 1'b0);
		rd(ADDR_STAT);
		cmp(d & 8'h10, 8'h10);
		rd(ADDR_CTRL1);
		cmp(d & 8'h10, 8'h10);
		cmp({4'h0, o_event_irq, o_wake, bus_sda, bus_scl}, 8'h0F);
		wr(ADDR_CTRL1, 8'h21);
		i_sleep <= 1'b0;
		$display("test stop done");
		// other master holds sda low while a one is sent
		start_send(8'hFF);
		repeat (4) @(posedge i_sys_clk);
		other_sda_low <= 1'b1;
		wait_bit(ADDR_CTRL1, C1_BCOL, 1'b1);
		rd(ADDR_STAT);
		cmp(d & 8'h01, 8'h00);
		rd(ADDR_CTRL2);
		cmp(d, 8'h00);
		cmp({6'h00, o_sda_oe, o_scl_oe}, 8'h00);
		wr(ADDR_CTRL1, 8'h21);
		other_sda_low <= 1'b0;
		wait_bit(ADDR_CTRL1, C1_EVT, 1'b1);
		$display("test collision done");
		// scl already low when a start begins
		@(posedge i_sys_clk);
		other_scl_low <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		wr(ADDR_CTRL2, 8'h01);
		wait_bit(ADDR_CTRL1, C1_BCOL, 1'b1);
		rd(ADDR_CTRL2);
		cmp(d, 8'h00);
		cmp({6'h00, o_sda_oe, o_scl_oe}, 8'h00);
		@(posedge i_sys_clk);
		other_scl_low <= 1'b0;
		repeat (10) @(posedge i_sys_clk);
		$display("test start collision done");
		// next byte after a collision starts at its first bit
		start_send(8'h5A);
		wait_bit(ADDR_CTRL1, C1_EVT, 1'b1);
		cmp(bits[8:1], 8'h5A);
		cmp(nclk[7:0], 8'h09);
		$display("test restart done");
		// reset in mid byte abandons it
		wr(ADDR_BUF, 8'hC3);
		repeat (10) @(posedge i_sys_clk);
		i_rst_n <= 1'b0;
		repeat (5) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		reset_rows();
		$display("test mid reset done");
		end_of_test();
	end
endmodule : tb

bind ims_cond_seq ims_cond_seq_sva i_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sda(i_sda), .o_sda(o_sda),
	.o_sda_oe(o_sda_oe), .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_sleep(i_sleep),
	.o_event_irq(o_event_irq), .o_wake(o_wake));
`default_nettype wire
